// ===== dv/osg_core_src.sv
`timescale 1ns/10ps
module osg_core_src (
    input wire logic sys_clk,
    input wire logic send,
    input wire logic [7:0] next_word,
    input wire logic core_ready,
    output logic [7:0] core_data,
    output logic core_valid
);
    logic taken = 1'b0;
    initial begin
        core_data = 8'h00;
        core_valid = 1'b0;
    end
    always @(posedge sys_clk) taken <= core_valid && core_ready;
    // Hold offer until taken; released data toggles
    always @(negedge sys_clk) begin
        if (taken || !core_valid) begin
            core_valid <= send;
            core_data <= send ? next_word : ~core_data;
        end
    end
endmodule

// ===== dv/osg_gearbox_chk.sv
`timescale 1ns/10ps
module osg_chk #(
    parameter int LANES = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] gear_mode,
    input wire logic fast_edge_clock_sel,
    input wire logic [LANES-1:0] core_data,
    input wire logic core_valid,
    input wire logic core_ready,
    input wire logic ser_out_first,
    input wire logic ser_out_second
);
    // ====
    // Checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic took_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) took_reg <= 1'b0;
        else if (core_valid && core_ready) took_reg <= 1'b1;
    end
    second_idle_a: assert property (gear_mode != 2'h3 |-> !ser_out_second) else $error("second out busy");
    early_bit_a: assert property ($rose(rst_n) |-> (!ser_out_first && !ser_out_second) [*4])
        else $error("bit too early");
    ready_reset_a: assert property ($rose(rst_n) |-> core_ready) else $error("not ready");
    no_word_idle_a: assert property (!took_reg |-> !ser_out_first && !ser_out_second)
        else $error("out without word");
    first_half_a: assert property (fast_edge_clock_sel && $changed(ser_out_first) |=> $stable(ser_out_first))
        else $error("first bit short");
    second_half_a: assert property (fast_edge_clock_sel && $changed(ser_out_second) |=> $stable(ser_out_second))
        else $error("second bit short");
    word_out_a: assert property (core_valid && core_ready && core_data[0] |-> ##[3:600] ser_out_first)
        else $error("word lost");
    full_cause_a: assert property (!core_ready && $past(core_ready) |-> $past(core_valid))
        else $error("full without take");
    cover property (!core_ready);
    cover property (gear_mode == 2'h3 && ser_out_second);
    cover property (fast_edge_clock_sel && $rose(ser_out_first));
    cover property (gear_mode == 2'h2 && ser_out_first);
endmodule
bind osg_gearbox osg_chk #(.LANES(LANES)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .gear_mode(gear_mode),
    .fast_edge_clock_sel(fast_edge_clock_sel), .core_data(core_data), .core_valid(core_valid),
    .core_ready(core_ready), .ser_out_first(ser_out_first), .ser_out_second(ser_out_second));

// ===== dv/osg_gearbox_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; $display("unexpected %0t %h %h", $time, a, b); end end
module osg_gearbox_tb;
    logic sys_clk = 0, rst_n = 0, fast_edge_clock_sel = 0, send = 0;
    logic [1:0] gear_mode = 2'h0;
    logic [7:0] next_word = 8'h11, core_data, got, exp;
    logic core_valid, core_ready, ser_out_first, ser_out_second;
    logic [7:0] q[$];
    logic [31:0] rng = 32'h5218;
    int mismatches = 0, n_tests = 0, pushed, seen_full, nb, dv, w;
    function automatic logic [7:0] rnd_word();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[7:0] | 8'h11;
    endfunction
    initial forever #5 sys_clk = ~sys_clk;
    osg_gearbox dut (.sys_clk(sys_clk), .rst_n(rst_n), .gear_mode(gear_mode),
        .fast_edge_clock_sel(fast_edge_clock_sel), .core_data(core_data), .core_valid(core_valid),
        .core_ready(core_ready), .ser_out_first(ser_out_first), .ser_out_second(ser_out_second));
    osg_core_src src (.sys_clk(sys_clk), .send(send), .next_word(next_word), .core_ready(core_ready),
        .core_data(core_data), .core_valid(core_valid));
    // ====
    // Model queue
    always @(posedge sys_clk) begin
        if (rst_n && core_valid && core_ready) begin
            q.push_back(core_data);
            pushed++;
            next_word <= rnd_word();
            if (pushed == 32) send <= 1'b0;
        end
        if (!core_ready) seen_full = 1;
    end
    task automatic end_of_test();
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end
    initial begin
        for (int i = 0; i < 8; i++) begin
            rst_n = 0;
            gear_mode = 2'(i / 2);
            fast_edge_clock_sel = i[0];
            repeat (4) @(negedge sys_clk);
            `CHK(ser_out_first | ser_out_second, 1'b0)
            `CHK(core_ready, 1'b1)
            q.delete();
            pushed = 0;
            seen_full = 0;
            rst_n = 1;
            @(posedge sys_clk);
            send = 1;
            @(negedge sys_clk);
            nb = gear_mode == 2'h0 ? 7 : gear_mode == 2'h3 ? 4 : 8;
            dv = fast_edge_clock_sel ? 2 : 1;
            w = 0;
            while (ser_out_first !== 1'b1 && w < 300) begin
                @(negedge sys_clk);
                w++;
            end
            for (int k = 0; k < 32; k++) begin
                got = 8'h00;
                for (int b = 0; b < nb; b++) begin
                    got[b] = ser_out_first;
                    if (nb == 4) got[b + 4] = ser_out_second;
                    repeat (dv) @(negedge sys_clk);
                end
                exp = q.size() ? q.pop_front() : 8'hxx;
                if (nb == 7) exp[7] = 1'b0;
                `CHK(got, exp)
            end
            `CHK(seen_full, 1)
            repeat (nb * dv) begin
                `CHK(ser_out_first | ser_out_second, 1'b0)
                @(negedge sys_clk);
            end
            $display("test %0d done", i);
        end
        end_of_test();
    end
endmodule

// ===== rtl/osg_fifo.sv
`timescale 1ns/10ps
module osg_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output logic [WIDTH-1:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic do_wr, do_rd;

    // ==========================================
    // Pointers and storage
    assign wr_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign rd_valid = (cnt_reg != '0);
    assign rd_data = mem_reg[rp_reg];
    assign do_wr = wr_valid && wr_ready;
    assign do_rd = rd_valid && rd_ready;

    always_comb begin
        mem_next = mem_reg;
        wp_next = wp_reg;
        rp_next = rp_reg;
        cnt_next = cnt_reg;
        if (do_wr) begin
            mem_next[wp_reg] = wr_data;
            wp_next = (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + AW'(1);
        end
        if (do_rd) begin
            rp_next = (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + AW'(1);
        end
        if (do_wr && !do_rd) begin
            cnt_next = cnt_reg + (AW+1)'(1);
        end else if (do_rd && !do_wr) begin
            cnt_next = cnt_reg - (AW+1)'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            mem_reg <= mem_next;
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule

// ===== rtl/osg_gearbox.sv
`timescale 1ns/10ps
module osg_gearbox #(
    parameter int LANES = osg_pkg::OSG_LANES,
    parameter int FIFO_DEPTH = osg_pkg::OSG_FIFO_DEPTH,
    parameter int EDGE1_DIV = osg_pkg::OSG_EDGE1_DIV
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] gear_mode,
    input wire logic fast_edge_clock_sel,
    input wire logic [LANES-1:0] core_data,
    input wire logic core_valid,
    output logic core_ready,
    output logic ser_out_first,
    output logic ser_out_second
);
    logic [LANES-1:0] fifo_data;
    logic fifo_valid, fifo_ready;
    logic [LANES-1:0] cap_reg, cap_next, xfer_reg, xfer_next, shift_reg, shift_next;
    logic cap_full_reg, cap_full_next, xfer_full_reg, xfer_full_next, shift_full_reg, shift_full_next;
    logic [2:0] bit_cnt_reg, bit_cnt_next, last_bit;
    logic [7:0] div_reg, div_next;
    logic q0_reg, q0_next, q1_reg, q1_next;
    logic bit_tick, word_end, pair_mode;
    logic xfer_free, cap_move, take_word;
    logic [LANES-1:0] lane_word;
    logic [LANES-1:0] shift_step;

    // ==========================================
    // Input buffer
    osg_fifo #(.WIDTH(LANES), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .wr_data(core_data),
        .wr_valid(core_valid),
        .wr_ready(core_ready),
        .rd_data(fifo_data),
        .rd_valid(fifo_valid),
        .rd_ready(fifo_ready)
    );

    // ==========================================
    // Mode decode
    always_comb begin
        pair_mode = 1'b0;
        case (osg_pkg::osg_mode_e'(gear_mode))
            osg_pkg::OSG_MODE_7TO1: last_bit = osg_pkg::OSG_LAST_7TO1;
            osg_pkg::OSG_MODE_8TO1: last_bit = osg_pkg::OSG_LAST_8TO1;
            osg_pkg::OSG_MODE_4TO1_PAIR: begin
                last_bit = osg_pkg::OSG_LAST_4TO1;
                pair_mode = 1'b1;
            end
            default: last_bit = osg_pkg::OSG_LAST_8TO1;
        endcase
    end

    // ==========================================
    // Edge clock select
    always_comb begin
        div_next = 8'h00;
        bit_tick = 1'b1;
        if (fast_edge_clock_sel) begin
            bit_tick = (div_reg == 8'(EDGE1_DIV - 1));
            div_next = bit_tick ? 8'h00 : div_reg + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_next;
        end
    end

    // ==========================================
    // Three stage pipeline
    assign word_end = bit_tick && (bit_cnt_reg == last_bit);

    // ==========================================
    // Stage hand-off
    assign xfer_free = !xfer_full_reg || word_end;
    assign cap_move = cap_full_reg && xfer_free;
    assign fifo_ready = !cap_full_reg || xfer_free;
    assign take_word = fifo_valid && fifo_ready;

    // ==========================================
    // Bit counter
    always_comb begin
        bit_cnt_next = bit_cnt_reg;
        if (bit_tick) begin
            bit_cnt_next = word_end ? osg_pkg::OSG_CNT_RST : bit_cnt_reg + 3'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg <= osg_pkg::OSG_CNT_RST;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    // ==========================================
    // Lane select
    always_comb begin
        lane_word = fifo_data;
        if (osg_pkg::osg_mode_e'(gear_mode) == osg_pkg::OSG_MODE_7TO1) begin
            lane_word[7] = 1'b0;
        end
    end

    // ==========================================
    // Stage one, capture on the word clock
    always_comb begin
        cap_next = cap_reg;
        cap_full_next = cap_full_reg;
        if (cap_move) begin
            cap_full_next = 1'b0;
        end
        if (take_word) begin
            cap_next = lane_word;
            cap_full_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_reg <= osg_pkg::OSG_WORD_RST;
            cap_full_reg <= 1'b0;
        end else begin
            cap_reg <= cap_next;
            cap_full_reg <= cap_full_next;
        end
    end

    // ==========================================
    // Stage two, move into edge clock registers
    always_comb begin
        xfer_next = xfer_reg;
        xfer_full_next = xfer_full_reg;
        if (word_end) begin
            xfer_full_next = 1'b0;
        end
        if (cap_move) begin
            xfer_next = cap_reg;
            xfer_full_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            xfer_reg <= osg_pkg::OSG_WORD_RST;
            xfer_full_reg <= 1'b0;
        end else begin
            xfer_reg <= xfer_next;
            xfer_full_reg <= xfer_full_next;
        end
    end

    // ==========================================
    // Shift step
    always_comb begin
        if (pair_mode) begin
            shift_step = {1'b0, shift_reg[7:5], 1'b0, shift_reg[3:1]};
        end else begin
            shift_step = {1'b0, shift_reg[7:1]};
        end
    end

    // ==========================================
    // Stage three, shift register
    always_comb begin
        shift_next = shift_reg;
        shift_full_next = shift_full_reg;
        if (bit_tick) begin
            shift_next = shift_step;
        end
        if (word_end) begin
            shift_full_next = xfer_full_reg;
            if (xfer_full_reg) begin
                shift_next = xfer_reg;
            end else begin
                shift_next = osg_pkg::OSG_WORD_RST;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= osg_pkg::OSG_WORD_RST;
            shift_full_reg <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            shift_full_reg <= shift_full_next;
        end
    end

    // ==========================================
    // Serial output bits
    always_comb begin
        q0_next = q0_reg;
        q1_next = q1_reg;
        if (bit_tick) begin
            if (shift_full_reg) begin
                q0_next = shift_reg[0];
                q1_next = pair_mode ? shift_reg[4] : osg_pkg::OSG_IDLE_BIT;
            end else begin
                q0_next = osg_pkg::OSG_IDLE_BIT;
                q1_next = osg_pkg::OSG_IDLE_BIT;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q0_reg <= osg_pkg::OSG_IDLE_BIT;
            q1_reg <= osg_pkg::OSG_IDLE_BIT;
        end else begin
            q0_reg <= q0_next;
            q1_reg <= q1_next;
        end
    end

    assign ser_out_first = q0_reg;
    assign ser_out_second = q1_reg;
endmodule

// ===== rtl/osg_pkg.sv
// Functional notes
// - Each top-edge cell serializes parallel core words at up to 8:1 onto one output, or onto two outputs in 4:1 pair mode.
// - Exactly one mode: 7:1 serializer, single 8:1 DDR, or two independent 4:1 DDR.
// - Lanes: 7:1 uses 6..0, 8:1 uses 7..0, 4:1 pair uses 3..0 and 7..4.
// - Stage one captures the parallel core word on the slow word clock.
// - Stage two moves the captured word into the fast edge clock registers.
// - Stage three shifts and multiplexes bits one by one onto the serial output.
package osg_pkg;
    // ==========================================
    // Modes and sizes
    typedef enum logic [1:0] {
        OSG_MODE_7TO1 = 2'b00,
        OSG_MODE_8TO1 = 2'b01,
        OSG_MODE_4TO1_PAIR = 2'b11
    } osg_mode_e;
    localparam int OSG_LANES = 8;
    localparam int OSG_FIFO_DEPTH = 16;
    localparam logic [2:0] OSG_LAST_7TO1 = 3'h6;
    localparam logic [2:0] OSG_LAST_8TO1 = 3'h7;
    localparam logic [2:0] OSG_LAST_4TO1 = 3'h3;
    localparam int OSG_EDGE1_DIV = 2;
    localparam logic OSG_IDLE_BIT = 1'b0;
    localparam logic [7:0] OSG_WORD_RST = 8'h00;
    localparam logic [2:0] OSG_CNT_RST = 3'h0;
endpackage
